// File: src/otp_lock_pkg.sv
package otp_lock_pkg;
    localparam int          ADDR_W          = 15;
    localparam int          DATA_W          = 8;
    localparam int          LOCK_W          = 2;
    localparam logic [1:0]  SEL_PROGRAM_STROBE_BYTE   = 2'h3;
    localparam logic [1:0]  SEL_LOCK_BITS   = 2'h2;
    localparam logic [1:0]  SEL_SIGNATURE   = 2'h1;
    localparam logic [1:0]  LOCK_LEVEL0     = 2'h3;
    localparam logic [1:0]  LOCK_LEVEL1     = 2'h2;
    localparam logic [1:0]  LOCK_LEVEL2     = 2'h1;
    localparam logic [1:0]  LOCK_LEVEL3     = 2'h0;
    localparam logic [1:0]  LOCK_ERASED     = 2'h3;
    localparam int          LOCK_BIT_HI     = 1;
    localparam int          LOCK_BIT_LO     = 0;
    // verification mode 2 timing, in oscillator periods
    localparam int          VER2_PERIOD_OSC = 6;
    localparam int          VER2_PULSE_OSC  = 1;
    localparam int          VER2_VALID_OSC  = 2;
    localparam int          VER2_STABLE_OSC = 4;
    localparam int          CNT_W           = 3;
    localparam logic [2:0]  CNT_LAST        = 3'(VER2_PERIOD_OSC - 1);
    localparam logic [2:0]  CNT_ZERO        = 3'h0;
    localparam logic [2:0]  CNT_DATA        = 3'(VER2_VALID_OSC - 1);
    localparam logic [7:0]  BYTE_ZERO       = 8'h00;
    localparam logic [7:0]  BYTE_ONES       = 8'hff;
    localparam logic [14:0] ADDR_ZERO       = 15'h0000;
    localparam logic [7:0]  SIG_BYTE0       = 8'h5a; // arbitrary value
    localparam logic [7:0]  SIG_BYTE1       = 8'ha5; // arbitrary value
    typedef enum logic [1:0] {ST_IDLE, ST_READ, ST_PROGRAM_STROBE} program_strobe_state_t;
endpackage : otp_lock_pkg

// File: src/otp_lock_and_access_modes.sv
// Contract
// R1 - sel 11: program code byte, address, data
// R2 - sel 10: program lock bits from d1,d0
// R3 - sel 01: read signature byte at address
// R4 - two lock bits, readable in lock mode
// R5 - level 0: no protection, no pin latch
// R6 - level 1+: block external table reads
// R7 - level 1+: latch access pin at reset
// R8 - level 1: code read only via mode 2
// R9 - level 1+: ignore code byte programming
// R10 - level 2: also block verify reads
// R11 - level 3: refuse pin-low external start
// R12 - level 3: internal jump outward still allowed
// R13 - mode 2: latch every 6, data timing
// R14 - lock level evaluated at reset, held
`timescale 1ns/1ps
`default_nettype none
module otp_lock_and_access_modes
    import otp_lock_pkg::*;
#(
    parameter int ADDR_WIDTH = ADDR_W
) (
    input  wire logic                  clk_i,
    input  wire logic                  rst_i,
    input  wire logic                  program_strobe_mode_en_i,
    input  wire logic [1:0]            program_strobe_mode_select_i,
    input  wire logic                  program_strobe_n_i,
    input  wire logic                  program_strobe_read_strobe_n_i,
    input  wire logic [ADDR_WIDTH-1:0] program_strobe_addr_i,
    input  wire logic [7:0]            program_strobe_data_i,
    input  wire logic                  verify2_en_i,
    input  wire logic                  external_access_pin_n_i,
    input  wire logic [1:0]            nv_lock_bits_i,
    input  wire logic [7:0]            code_rd_data_i,
    input  wire logic                  code_table_read_instr_i,
    input  wire logic                  exec_from_external_i,
    input  wire logic                  internal_jump_out_i,
    output logic [7:0]                 program_strobe_data_o,
    output logic                       program_strobe_data_oe_o,
    output logic                       program_strobe_address_latch_o,
    output logic [ADDR_WIDTH-1:0]      code_addr_o,
    output logic [7:0]                 code_wr_data_o,
    output logic                       code_wr_o,
    output logic [1:0]                 lock_wr_data_o,
    output logic                       lock_wr_o,
    output logic [1:0]                 lock_level_o,
    output logic                       ext_access_latched_n_o,
    output logic                       table_read_block_o,
    output logic                       external_exec_en_o
);
    // the mode, strobe, address, data and access pins pass two flops before use
    logic [1:0]            sel_s1_r, sel_s2_r;
    logic                  prg_s1_r, prg_s2_r, prg_s3_r;
    logic                  rd_s1_r, rd_s2_r;
    logic                  en_s1_r, en_s2_r;
    logic                  v2_s1_r, v2_s2_r;
    logic                  acc_s1_r, acc_s2_r;
    logic [ADDR_WIDTH-1:0] addr_s1_r, addr_s2_r;
    logic [7:0]            din_s1_r, din_s2_r;

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            sel_s1_r  <= 2'h0;
            sel_s2_r  <= 2'h0;
            prg_s1_r  <= 1'b1;
            prg_s2_r  <= 1'b1;
            prg_s3_r  <= 1'b1;
            rd_s1_r   <= 1'b1;
            rd_s2_r   <= 1'b1;
            en_s1_r   <= 1'b0;
            en_s2_r   <= 1'b0;
            v2_s1_r   <= 1'b0;
            v2_s2_r   <= 1'b0;
            addr_s1_r <= '0;
            addr_s2_r <= '0;
            din_s1_r  <= BYTE_ZERO;
            din_s2_r  <= BYTE_ZERO;
        end else begin
            sel_s1_r  <= program_strobe_mode_select_i;
            sel_s2_r  <= sel_s1_r;
            prg_s1_r  <= program_strobe_n_i;
            prg_s2_r  <= prg_s1_r;
            prg_s3_r  <= prg_s2_r;
            rd_s1_r   <= program_strobe_read_strobe_n_i;
            rd_s2_r   <= rd_s1_r;
            en_s1_r   <= program_strobe_mode_en_i;
            en_s2_r   <= en_s1_r;
            v2_s1_r   <= verify2_en_i;
            v2_s2_r   <= v2_s1_r;
            addr_s1_r <= program_strobe_addr_i;
            addr_s2_r <= addr_s1_r;
            din_s1_r  <= program_strobe_data_i;
            din_s2_r  <= din_s1_r;
        end
    end

    // no reset here: the latch below must see the real pin on release
    always_ff @(posedge clk_i) begin
        acc_s1_r <= external_access_pin_n_i;
        acc_s2_r <= acc_s1_r;
    end

    // lock level captured once after reset release; access pin latched then at level 1+, tracked at level 0
    logic [1:0] level_r, level_nxt;
    logic       acc_r, acc_nxt;
    logic       caught_r, caught_nxt;

    always_comb begin
        level_nxt  = level_r;
        acc_nxt    = acc_r;
        caught_nxt = 1'b1;
        if (!caught_r) begin
            // R14 level from store
            level_nxt = nv_lock_bits_i;
            // R7 latch access pin
            if (nv_lock_bits_i != LOCK_LEVEL0) begin
                acc_nxt = acc_s2_r;
            end
        end
        // R5 level 0 follows pin
        if (caught_r && level_r == LOCK_LEVEL0) begin
            acc_nxt = acc_s2_r;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            level_r  <= LOCK_ERASED;
            acc_r    <= 1'b1;
            caught_r <= 1'b0;
        end else begin
            level_r  <= level_nxt;
            acc_r    <= acc_nxt;
            caught_r <= caught_nxt;
        end
    end

    // protection decode
    logic prot_any, prot_ver, prot_l3;
    assign prot_any = (level_r != LOCK_LEVEL0);
    assign prot_ver = (level_r == LOCK_LEVEL2) || (level_r == LOCK_LEVEL3);
    assign prot_l3  = (level_r == LOCK_LEVEL3);

    // programming and read paths
    logic                  program_strobe_fall;
    logic [7:0]            dout_r, dout_nxt;
    logic                  oe_r, oe_nxt;
    logic [ADDR_WIDTH-1:0] caddr_r, caddr_nxt;
    logic [7:0]            cwd_r, cwd_nxt;
    logic                  cwr_r, cwr_nxt;
    logic [1:0]            lwd_r, lwd_nxt;
    logic                  lwr_r, lwr_nxt;
    logic [CNT_W-1:0]      cnt_r, cnt_nxt;
    logic                  ale_r, ale_nxt;
    logic                  tbl_r, tbl_nxt;
    logic                  xex_r, xex_nxt;

    assign program_strobe_fall = prg_s3_r && !prg_s2_r;

    always_comb begin
        dout_nxt  = dout_r;
        oe_nxt    = 1'b0;
        caddr_nxt = caddr_r;
        cwd_nxt   = cwd_r;
        cwr_nxt   = 1'b0;
        lwd_nxt   = lwd_r;
        lwr_nxt   = 1'b0;
        cnt_nxt   = CNT_ZERO;
        ale_nxt   = 1'b0;
        if (en_s2_r && !v2_s2_r) begin
            caddr_nxt = addr_s2_r;
            if (program_strobe_fall) begin
                case (sel_s2_r)
                    SEL_PROGRAM_STROBE_BYTE: begin
                        // R1 code byte program
                        cwd_nxt = din_s2_r;
                        // R9 no reprogramming
                        cwr_nxt = !prot_any;
                    end
                    SEL_LOCK_BITS: begin
                        // R2 lock bits from d1,d0
                        lwd_nxt = din_s2_r[1:0];
                        lwr_nxt = 1'b1;
                    end
                    default: ;
                endcase
            end
            if (!rd_s2_r) begin
                oe_nxt = 1'b1;
                case (sel_s2_r)
                    SEL_PROGRAM_STROBE_BYTE: begin
                        // R8 R10 verify read blocked
                        dout_nxt = prot_any ? BYTE_ONES : code_rd_data_i;
                    end
                    SEL_LOCK_BITS: begin
                        // R4 lock state read
                        dout_nxt = {6'h00, level_r};
                    end
                    SEL_SIGNATURE: begin
                        // R3 signature byte
                        dout_nxt = addr_s2_r[0] ? SIG_BYTE1 : SIG_BYTE0;
                    end
                    default: dout_nxt = BYTE_ZERO;
                endcase
            end
        end else if (en_s2_r && v2_s2_r) begin
            // R13 six-period address latch cycle
            cnt_nxt = (cnt_r == CNT_LAST) ? CNT_ZERO : cnt_r + 3'h1;
            ale_nxt = (cnt_r == CNT_LAST);
            oe_nxt  = 1'b1;
            if (cnt_r == CNT_ZERO) begin
                caddr_nxt = caddr_r + 1'b1;
            end
            // R13 data valid, stable four
            if (cnt_r == CNT_DATA) begin
                // R8 R10 mode 2 allowed below level 2
                dout_nxt = prot_ver ? BYTE_ONES : code_rd_data_i;
            end
        end
        // R6 block external table reads
        tbl_nxt = prot_any && code_table_read_instr_i && exec_from_external_i;
        // R11 R12 pin-low start refused
        xex_nxt = prot_l3 ? internal_jump_out_i : (!acc_r || internal_jump_out_i);
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            dout_r  <= BYTE_ZERO;
            oe_r    <= 1'b0;
            caddr_r <= ADDR_ZERO[ADDR_WIDTH-1:0];
            cwd_r   <= BYTE_ZERO;
            cwr_r   <= 1'b0;
            lwd_r   <= LOCK_ERASED;
            lwr_r   <= 1'b0;
            cnt_r   <= CNT_ZERO;
            ale_r   <= 1'b0;
            tbl_r   <= 1'b0;
            xex_r   <= 1'b0;
        end else begin
            dout_r  <= dout_nxt;
            oe_r    <= oe_nxt;
            caddr_r <= caddr_nxt;
            cwd_r   <= cwd_nxt;
            cwr_r   <= cwr_nxt;
            lwd_r   <= lwd_nxt;
            lwr_r   <= lwr_nxt;
            cnt_r   <= cnt_nxt;
            ale_r   <= ale_nxt;
            tbl_r   <= tbl_nxt;
            xex_r   <= xex_nxt;
        end
    end

    assign program_strobe_data_o          = dout_r;
    assign program_strobe_data_oe_o       = oe_r;
    assign program_strobe_address_latch_o = ale_r;
    assign code_addr_o          = caddr_r;
    assign code_wr_data_o       = cwd_r;
    assign code_wr_o            = cwr_r;
    assign lock_wr_data_o       = lwd_r;
    assign lock_wr_o            = lwr_r;
    assign lock_level_o         = level_r;
    assign ext_access_latched_n_o = acc_r;
    assign table_read_block_o   = tbl_r;
    assign external_exec_en_o   = xex_r;
endmodule : otp_lock_and_access_modes
`default_nettype wire

// File: sim/otp_lock_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module otp_lock_checker
    import otp_lock_pkg::*;
(
    input wire logic       clk_i,
    input wire logic       rst_i,
    input wire logic       program_strobe_mode_en_i,
    input wire logic       verify2_en_i,
    input wire logic       internal_jump_out_i,
    input wire logic [7:0] program_strobe_data_o,
    input wire logic       program_strobe_address_latch_o,
    input wire logic       code_wr_o,
    input wire logic [1:0] lock_level_o,
    input wire logic       ext_access_latched_n_o,
    input wire logic       table_read_block_o,
    input wire logic       external_exec_en_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // only a period with mode 2 kept up counts
    sequence s_period;
        program_strobe_address_latch_o ##1 (program_strobe_mode_en_i && verify2_en_i) [*6];
    endsequence
    ale_spacing_a: assert property (program_strobe_address_latch_o |=> !program_strobe_address_latch_o [*5])
        else $error("latch gap");
    ale_period_a: assert property (s_period |-> program_strobe_address_latch_o)
        else $error("latch period");
    verify_block_a: assert property (
        s_period ##0 !lock_level_o[LOCK_BIT_HI] |-> program_strobe_data_o == BYTE_ONES)
        else $error("verify read open");
    program_strobe_refuse_a: assert property (code_wr_o |-> lock_level_o == LOCK_LEVEL0)
        else $error("write when locked");
    table_block_a: assert property (table_read_block_o |-> lock_level_o != LOCK_LEVEL0)
        else $error("table block at level 0");
    // the first edge after release loads level and pin, so two edges are skipped
    level_hold_a: assert property (
        !$past(rst_i) && !$past(rst_i, 2) |-> $stable(lock_level_o))
        else $error("level moved");
    pin_hold_a: assert property (
        lock_level_o != LOCK_LEVEL0 && !$past(rst_i) && !$past(rst_i, 2)
        |-> $stable(ext_access_latched_n_o))
        else $error("access pin not held");
    ext_refuse_a: assert property (
        !internal_jump_out_i [*3] ##0 lock_level_o == LOCK_LEVEL3 |-> !external_exec_en_o)
        else $error("external start at level 3");
endmodule : otp_lock_checker
bind otp_lock_and_access_modes otp_lock_checker chk (
    .clk_i, .rst_i, .program_strobe_mode_en_i, .verify2_en_i, .internal_jump_out_i, .program_strobe_data_o,
    .program_strobe_address_latch_o, .code_wr_o, .lock_level_o, .ext_access_latched_n_o,
    .table_read_block_o, .external_exec_en_o);
`default_nettype wire

// File: sim/otp_programmer_model.sv
`timescale 1ns/1ps
`default_nettype none
module otp_programmer_model (
    input  wire logic        clk_i,
    input  wire logic [7:0]  dout_i,
    output var  logic        en_o,
    output var  logic [1:0]  sel_o,
    output var  logic        program_strobe_n_o,
    output var  logic        rd_n_o,
    output var  logic [14:0] addr_o,
    output var  logic [7:0]  data_o
);
    initial begin
        en_o = 1'b0;
        sel_o = 2'h0;
        program_strobe_n_o = 1'b1;
        rd_n_o = 1'b1;
        addr_o = 15'h0000;
        data_o = 8'h00;
    end
    // lines then strobe
    // lines lead by three edges so the synchroniser sees them first
    task automatic access(input logic [1:0] s, input logic [14:0] a, input logic [7:0] d,
                          input logic rd, output logic [7:0] q);
        en_o <= 1'b1;
        sel_o <= s;
        addr_o <= a;
        data_o <= d;
        repeat (3) @(posedge clk_i);
        if (rd) rd_n_o <= 1'b0;
        else program_strobe_n_o <= 1'b0;
        repeat (6) @(posedge clk_i);
        q = dout_i;
        rd_n_o <= 1'b1;
        program_strobe_n_o <= 1'b1;
        repeat (3) @(posedge clk_i);
        data_o <= ~d;
        // one edge before the next call may drive the lines again
        @(posedge clk_i);
    endtask : access
endmodule : otp_programmer_model
`default_nettype wire

// File: sim/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench
    import otp_lock_pkg::*;
;
    logic clk_i = 1'b0, rst_i = 1'b1, external_access_pin_n_i = 1'b0, verify2_en_i = 1'b0;
    logic code_table_read_instr_i = 1'b1, exec_from_external_i = 1'b1, internal_jump_out_i = 1'b0;
    logic [1:0]  nv_lock_bits_i = 2'h3, program_strobe_mode_select_i, lock_wr_data_o, lock_level_o, lk;
    logic [14:0] program_strobe_addr_i, code_addr_o;
    logic [7:0]  program_strobe_data_i, program_strobe_data_o, code_wr_data_o, q;
    logic [22:0] wr;
    logic        program_strobe_mode_en_i, program_strobe_n_i, program_strobe_read_strobe_n_i, program_strobe_data_oe_o;
    logic        program_strobe_address_latch_o, code_wr_o, lock_wr_o, ext_access_latched_n_o;
    logic        table_read_block_o, external_exec_en_o;
    wire logic [7:0] code_rd_data_i = code_addr_o[7:0] ^ 8'h3c;
    int          failures = 0, comparisons = 0, wr_cnt = 0, k;
    always #25 clk_i = ~clk_i;
    otp_lock_and_access_modes dut (.clk_i, .rst_i, .program_strobe_mode_en_i, .program_strobe_mode_select_i,
        .program_strobe_n_i, .program_strobe_read_strobe_n_i, .program_strobe_addr_i, .program_strobe_data_i, .verify2_en_i,
        .external_access_pin_n_i, .nv_lock_bits_i, .code_rd_data_i, .code_table_read_instr_i,
        .exec_from_external_i, .internal_jump_out_i, .program_strobe_data_o, .program_strobe_data_oe_o,
        .program_strobe_address_latch_o, .code_addr_o, .code_wr_data_o, .code_wr_o, .lock_wr_data_o,
        .lock_wr_o, .lock_level_o, .ext_access_latched_n_o, .table_read_block_o,
        .external_exec_en_o);
    otp_programmer_model pm (.clk_i, .dout_i(program_strobe_data_o), .en_o(program_strobe_mode_en_i),
        .sel_o(program_strobe_mode_select_i), .program_strobe_n_o(program_strobe_n_i),
        .rd_n_o(program_strobe_read_strobe_n_i), .addr_o(program_strobe_addr_i), .data_o(program_strobe_data_i));
    always @(posedge clk_i) begin
        if (code_wr_o === 1'b1) begin
            wr_cnt <= wr_cnt + 1;
            wr <= {code_addr_o, code_wr_data_o};
        end
        if (lock_wr_o === 1'b1) lk <= lock_wr_data_o;
    end
    task automatic check(input string n, input logic [22:0] seen, input logic [22:0] exp);
        comparisons++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] %s exp %h seen %h", n, exp, seen);
        end
    endtask : check
    task automatic wrap_up;
        if (failures == 0 && comparisons > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : wrap_up
    // access pin held steady through reset so the latch sees a settled level
    task automatic restart(input logic [1:0] lvl, input logic pin);
        rst_i <= 1'b1;
        nv_lock_bits_i <= lvl;
        external_access_pin_n_i <= pin;
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (4) @(posedge clk_i);
        check("level", lock_level_o, lvl);
    endtask : restart
    initial begin
        repeat (5000) @(posedge clk_i);
        failures++;
        wrap_up();
    end
    initial begin
        restart(LOCK_LEVEL0, 1'b0);
        external_access_pin_n_i <= 1'b1;
        repeat (5) @(posedge clk_i);
        check("pin track", ext_access_latched_n_o, 1'b1);
        check("tbl open", table_read_block_o, 1'b0);
        pm.access(SEL_PROGRAM_STROBE_BYTE, 15'h4321, 8'h9c, 1'b0, q);
        check("wr", wr, {15'h4321, 8'h9c});
        pm.access(SEL_LOCK_BITS, 15'h0000, 8'hfd, 1'b0, q);
        check("lock wr", lk, 2'h1);
        pm.access(SEL_LOCK_BITS, 15'h0000, 8'h00, 1'b1, q);
        check("lock rd", q[1:0], LOCK_LEVEL0);
        check("oe off", program_strobe_data_oe_o, 1'b0);
        pm.access(SEL_SIGNATURE, 15'h0000, 8'h00, 1'b1, q);
        check("sig0", q, SIG_BYTE0);
        pm.access(SEL_SIGNATURE, 15'h0001, 8'h00, 1'b1, q);
        check("sig1", q, SIG_BYTE1);
        pm.access(SEL_PROGRAM_STROBE_BYTE, 15'h0012, 8'h00, 1'b1, q);
        check("code rd", q, 8'h12 ^ 8'h3c);
        for (int l = 0; l < 3; l++) begin
            restart(2'(2 - l), l != 2);
            external_access_pin_n_i <= l == 2;
            repeat (5) @(posedge clk_i);
            check("pin held", ext_access_latched_n_o, l != 2);
            check("exec", external_exec_en_o, 1'b0);
            check("tbl shut", table_read_block_o, 1'b1);
            internal_jump_out_i <= 1'b1;
            exec_from_external_i <= 1'b0;
            repeat (4) @(posedge clk_i);
            check("jump", external_exec_en_o, 1'b1);
            check("tbl internal", table_read_block_o, 1'b0);
            internal_jump_out_i <= 1'b0;
            exec_from_external_i <= 1'b1;
            code_table_read_instr_i <= 1'b0;
            k = wr_cnt;
            pm.access(SEL_PROGRAM_STROBE_BYTE, 15'h0040, 8'h11, 1'b0, q);
            check("wr refuse", wr_cnt, k);
            check("tbl idle", table_read_block_o, 1'b0);
            code_table_read_instr_i <= 1'b1;
            pm.access(SEL_PROGRAM_STROBE_BYTE, 15'h0012, 8'h00, 1'b1, q);
            check("rd refuse", q, BYTE_ONES);
            verify2_en_i <= 1'b1;
            k = 0;
            while (program_strobe_address_latch_o !== 1'b1 && k < 60) begin
                @(posedge clk_i);
                k++;
            end
            repeat (3) @(posedge clk_i);
            // entry and the first latch pulse each step the address on from 12
            check("mode2", program_strobe_data_o, l == 0 ? 8'h14 ^ 8'h3c : BYTE_ONES);
            check("mode2 addr", code_addr_o, 15'h0014);
            check("mode2 oe", program_strobe_data_oe_o, 1'b1);
            repeat (12) @(posedge clk_i);
            verify2_en_i <= 1'b0;
        end
        wrap_up();
    end
endmodule : testbench
`default_nettype wire
